/* File: inc/nism_pkg.sv */
// Package of constants and carriers for the network interrupt status and mask block.
package nism_pkg;

  // Printed offsets are not all multiples of four, so they are indices.
  localparam logic [7:0] STATUS_IDX = 8'h12;
  localparam logic [7:0] MASK_IDX = 8'h14;
  localparam logic [7:0] OPCODE_IDX = 8'h16;
  localparam logic [7:0] SEARCH_IDX = 8'h1a;
  localparam logic [7:0] ERROR_INFO_REGISTER_IDX = 8'h08;
  localparam logic [7:0] CONTROL_IDX = 8'h09;
  localparam logic [9:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
  localparam logic [9:0] MASK_ADDR = {MASK_IDX, 2'b00};
  localparam logic [9:0] OPCODE_ADDR = {OPCODE_IDX, 2'b00};
  localparam logic [9:0] SEARCH_ADDR = {SEARCH_IDX, 2'b00};
  localparam logic [9:0] ERROR_INFO_REGISTER_ADDR = {ERROR_INFO_REGISTER_IDX, 2'b00};
  localparam logic [9:0] CONTROL_ADDR = {CONTROL_IDX, 2'b00};

  // Status bit positions.
  localparam int B_RECEIVE_ERROR_FLAG = 15;
  localparam int B_DECODE = 14;
  localparam int B_UNLOCK = 13;
  localparam int B_WATCH = 12;
  localparam int B_FREE = 11;
  localparam int B_REMOTE = 10;
  localparam int B_OWN = 9;
  localparam int B_SID = 8;
  localparam int B_RETRY = 7;
  localparam int B_REPLY = 6;
  localparam int B_HUBWD = 5;
  localparam int B_PAGE = 4;
  localparam int B_CORE = 3;
  localparam int B_ENQ = 2;
  localparam int B_TRANSMIT_ERROR_FLAG = 1;
  localparam int B_AVAIL = 0;

  // Bits that software clears by writing one.
  localparam logic [15:0] W1C_MASK = 16'hcff6;
  localparam logic [15:0] STATUS_RESET = 16'h2001;
  localparam logic [15:0] MASK_RESET = 16'h0000;

  // Command codes.
  localparam logic [7:0] CMD_SEND = 8'h03;
  localparam logic [7:0] CMD_WATCH_CLR = 8'h0a;

  // Bad page pointer range top and core mask layout.
  localparam logic [7:0] PAGE_PTR_MAX_BAD = 8'h02;
  localparam int CORE_SRC_W = 4;

  // Hub watchdog times in microseconds, tenths, and clock rate in kHz.
  localparam int HUB_WD_SLOW_US10 = 32700;
  localparam int HUB_WD_FAST_US10 = 16400;
  localparam int CLK_KHZ = 10000;
  // Tenths of a microsecond times kHz over 10000 gives whole cycles, rounded up.
  localparam int HUB_WD_SLOW_CYC = (HUB_WD_SLOW_US10 * CLK_KHZ + 9999) / 10000;
  localparam int HUB_WD_FAST_CYC = (HUB_WD_FAST_US10 * CLK_KHZ + 9999) / 10000;

  // Receive event carrier from the receive engine.
  typedef struct packed {
    logic err_abort;
    logic [2:0] err_code;
    logic [4:0] err_sender;
    logic decode_fix;
    logic [3:0] decode_info;
    logic free_done;
    logic remote_done;
    logic own_done;
    logic pkt_done;
    logic [4:0] pkt_source;
  } nism_rx_s;

  // Transmit event carrier from the transmit engine.
  typedef struct packed {
    logic token_retry;
    logic reply_recover;
    logic tx_fail;
    logic enq_noreply;
    logic sent;
    logic [7:0] sent_page_ptr;
    logic [7:0] page_limit;
    logic done;
  } nism_tx_s;

  typedef enum logic [1:0] {
    NISM_TX_BUSY,
    NISM_TX_DONE,
    NISM_TX_DATA_ERR,
    NISM_TX_NO_REPLY
  } nism_txstate_e;

endpackage

/* File: verilog/nism_top.sv */
// Interrupt status and mask logic of the token-passing network controller.
//
// How it works
// (R01) Interrupt output is high when any status bit and its mask bit are both one.
// (R02) Receive abort sets bit 15 and stores error code and sender id.
// (R03) Writing one clears a writable flag; software reset clears them too.
// (R04) Decoder correction sets bit 14 and stores correction detail bits 11 to 8.
// (R05) Bit 13 is read-only unlock flag, forced to one by software reset.
// (R06) Unlock flag holds one after master id load until node is master.
// (R07) Watch timeout sets bit 12; cleared only by command or software reset.
// (R08) Free-format page receive done sets bit 11.
// (R09) Remote-buffer page receive done sets bit 10.
// (R10) Packet for this node received sets bit 9.
// (R11) Source id equal to search register sets bit 8.
// (R12) Token retry sets bit 7.
// (R13) Corrupt reply recovery applied sets bit 6.
// (R14) Hub transmit active past watchdog time resets hub, coders, sets bit 5.
// (R15) With hub off, coders are not reset on hub watchdog timeout.
// (R16) Sent page pointer beyond boundary or 00h to 02h sets bit 4.
// (R17) Bit 3 shows an enabled core interrupt source.
// (R18) Enquiry without reply sets bits 2 and 1 together.
// (R19) Send failure sets bit 1; write one, soft reset or send clears 1 and 2.
// (R20) Bit 0 mirrors transmitter available, resets to one, zero while send pending.
// (R21) Transmit state decodes from bits 0, 1 and 2.
// (R22) Send command code 03h arms transmission until the next token.
// (R23) Command 0Ah restarts watch timer, clears watch and remote-buffer flags.
// (R24) Zero writes and writes to read-only bits change nothing.
//
// Chosen here: the APB interface to the registers.
module nism_top
  import nism_pkg::*;
#(
  parameter int HUB_WD_SLOW = HUB_WD_SLOW_CYC,
  parameter int HUB_WD_FAST = HUB_WD_FAST_CYC,
  parameter int WATCH_CYCLES = 100000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire nism_rx_s rx_ev,
  input wire nism_tx_s tx_ev,
  input wire logic token_rx,
  input wire logic hub_tx_active,
  input wire logic hub_on,
  input wire logic fast_rate,
  input wire logic master_id_loaded,
  input wire logic self_is_master,
  input wire logic [CORE_SRC_W-1:0] core_src,
  output logic irq,
  output logic hub_reset,
  output logic coder_reset,
  output logic send_armed,
  output logic watch_restart,
  output logic remote_flags_clear,
  output nism_txstate_e tx_state
);

  // All checks run on the bus clock and rest while hardware reset is low.
  default clocking main_cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode. Every access completes in its first access cycle.
  logic wr, rd_en;
  logic [15:0] wdat;
  logic [15:0] status_q, mask_q;
  logic [15:0] error_info_register_q;
  logic [4:0] search_q;
  logic [7:0] opcode_q;
  logic [4:0] control_q;
  logic soft_reset, send_cmd, watch_cmd;
  logic known;

  // A register answers only on its own aligned byte address.
  function automatic logic hit(input logic [11:0] a, input logic [9:0] r);
    return a == {2'b00, r};
  endfunction

  assign known = hit(paddr, STATUS_ADDR) | hit(paddr, MASK_ADDR) | hit(paddr, OPCODE_ADDR) |
                 hit(paddr, SEARCH_ADDR) | hit(paddr, ERROR_INFO_REGISTER_ADDR) | hit(paddr, CONTROL_ADDR);
  assign wr = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite; // Setup cycle of a read.
  assign wdat = pwdata[15:0];
  assign pready = 1'b1;
  // Unmapped addresses answer with an error and store nothing.
  assign pslverr = psel & penable & ~known;
  assign send_cmd = wr & hit(paddr, OPCODE_ADDR) & (wdat[7:0] == CMD_SEND); // (R22)
  assign watch_cmd = wr & hit(paddr, OPCODE_ADDR) & (wdat[7:0] == CMD_WATCH_CLR); // (R23)
  // Software reset is a level held in control bit 0.
  assign soft_reset = control_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // Host-written registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= MASK_RESET;
      search_q <= 5'h00;
      opcode_q <= 8'h00;
      control_q <= 5'h00;
    end else if (wr) begin
      if (hit(paddr, MASK_ADDR)) mask_q <= wdat;
      if (hit(paddr, SEARCH_ADDR)) search_q <= wdat[4:0];
      if (hit(paddr, OPCODE_ADDR)) opcode_q <= wdat[7:0];
      if (hit(paddr, CONTROL_ADDR)) control_q <= wdat[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data is registered at the setup edge so it stands through the access cycle;
  // the value shown is therefore the state one cycle before the access edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= 32'h0000_0000;
      if (hit(paddr, STATUS_ADDR)) prdata <= {16'h0000, status_q};
      if (hit(paddr, MASK_ADDR)) prdata <= {16'h0000, mask_q};
      if (hit(paddr, OPCODE_ADDR)) prdata <= {24'h000000, opcode_q};
      if (hit(paddr, SEARCH_ADDR)) prdata <= {27'h0000000, search_q};
      if (hit(paddr, ERROR_INFO_REGISTER_ADDR)) prdata <= {16'h0000, error_info_register_q};
      if (hit(paddr, CONTROL_ADDR)) prdata <= {27'h0000000, control_q};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Send arming: pending from the send command until the next token finishes it.
  // The next value also feeds status bit 0, so that bit falls in the same cycle
  // as the arming register rises and never shows a stale one.
  logic armed_q, armed_d;
  always_comb begin
    armed_d = armed_q;
    if (soft_reset) begin
      armed_d = 1'b0;
    end else if (send_cmd) begin
      armed_d = 1'b1; // (R22)
    end else if (armed_q & token_rx & tx_ev.done) begin
      armed_d = 1'b0; // (R22)
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) armed_q <= 1'b0;
    else armed_q <= armed_d;
  end
  assign send_armed = armed_q;

  ////////////////////////////////////////////////////////////////////////////
  // Watch timer for remote-buffer receive pages.
  logic [31:0] watch_q;
  logic watch_hit;
  assign watch_hit = (watch_q == 32'(WATCH_CYCLES - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) watch_q <= 32'h0000_0000;
    else if (soft_reset | watch_cmd | rx_ev.remote_done | watch_hit) watch_q <= 32'h0000_0000; // (R23)
    else watch_q <= watch_q + 32'h0000_0001;
  end
  assign watch_restart = watch_cmd;
  assign remote_flags_clear = watch_cmd; // (R23)

  ////////////////////////////////////////////////////////////////////////////
  // Hub watchdog: counts while the hub transmit signal stays active.
  logic [15:0] hub_q;
  logic hub_to, hub_to_q;
  assign hub_to = hub_tx_active & (hub_q == 16'(fast_rate ? HUB_WD_FAST - 1 : HUB_WD_SLOW - 1)); // (R14)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hub_q <= 16'h0000;
    else if (!hub_tx_active | hub_to) hub_q <= 16'h0000;
    else hub_q <= hub_q + 16'h0001;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hub_to_q <= 1'b0;
    else hub_to_q <= hub_to;
  end
  // Resets pulse one cycle; the flag follows in the cycle after the reset pulse.
  assign hub_reset = hub_to_q; // (R14)
  assign coder_reset = hub_to_q & hub_on; // (R15)

  ////////////////////////////////////////////////////////////////////////////
  // Error info capture.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) error_info_register_q <= 16'h0000;
    else begin
      if (rx_ev.err_abort) error_info_register_q[7:0] <= {rx_ev.err_code, rx_ev.err_sender}; // (R02)
      if (rx_ev.decode_fix) error_info_register_q[11:8] <= rx_ev.decode_info; // (R04)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flag events; set wins over write-one and command clears, software reset wins over set.
  logic [15:0] set_v, clr_v, status_d;
  logic page_bad;
  assign page_bad = tx_ev.sent & ((tx_ev.sent_page_ptr > tx_ev.page_limit) |
                                  (tx_ev.sent_page_ptr <= PAGE_PTR_MAX_BAD)); // (R16)
  always_comb begin
    set_v = 16'h0000;
    set_v[B_RECEIVE_ERROR_FLAG] = rx_ev.err_abort; // (R02)
    set_v[B_DECODE] = rx_ev.decode_fix; // (R04)
    set_v[B_WATCH] = watch_hit; // (R07)
    set_v[B_FREE] = rx_ev.free_done; // (R08)
    set_v[B_REMOTE] = rx_ev.remote_done; // (R09)
    set_v[B_OWN] = rx_ev.own_done; // (R10)
    set_v[B_SID] = rx_ev.pkt_done & (rx_ev.pkt_source == search_q); // (R11)
    set_v[B_RETRY] = tx_ev.token_retry; // (R12)
    set_v[B_REPLY] = tx_ev.reply_recover; // (R13)
    set_v[B_HUBWD] = hub_to_q; // (R14)
    set_v[B_PAGE] = page_bad; // (R16)
    set_v[B_ENQ] = tx_ev.enq_noreply; // (R18)
    set_v[B_TRANSMIT_ERROR_FLAG] = tx_ev.tx_fail | tx_ev.enq_noreply; // (R18) (R19)
    clr_v = (wr & hit(paddr, STATUS_ADDR)) ? (wdat & W1C_MASK) : 16'h0000; // (R03) (R24)
    if (send_cmd) begin
      clr_v[B_ENQ] = 1'b1; // (R19)
      clr_v[B_TRANSMIT_ERROR_FLAG] = 1'b1; // (R19)
    end
    if (watch_cmd) clr_v[B_WATCH] = 1'b1; // (R07) (R23)
    status_d = (status_q & ~clr_v) | set_v;
    // Read-only live bits.
    status_d[B_UNLOCK] = soft_reset | (master_id_loaded & ~self_is_master); // (R05) (R06)
    status_d[B_CORE] = |(core_src & control_q[4:1]); // (R17)
    status_d[B_AVAIL] = ~armed_d; // (R20)
    if (soft_reset) begin
      status_d = STATUS_RESET; // (R03) (R05)
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) status_q <= STATUS_RESET;
    else status_q <= status_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt and transmit state decode.
  assign irq = |(status_q & mask_q); // (R01)
  always_comb begin
    if (!status_q[B_AVAIL]) tx_state = NISM_TX_BUSY; // (R21)
    else if (!status_q[B_TRANSMIT_ERROR_FLAG]) tx_state = NISM_TX_DONE;
    else if (status_q[B_ENQ]) tx_state = NISM_TX_NO_REPLY;
    else tx_state = NISM_TX_DATA_ERR;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  sequence w1c_write_s;
    wr && hit(paddr, STATUS_ADDR);
  endsequence

  irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // (R01)
    irq == |(status_q & mask_q)) else $error("irq does not follow status and mask");
  receive_error_flag_set_a: assert property (@(posedge pclk) disable iff (!presetn) // (R02)
    rx_ev.err_abort && !soft_reset |=> status_q[B_RECEIVE_ERROR_FLAG] && error_info_register_q[4:0] == $past(rx_ev.err_sender))
    else $error("receive error not captured");
  w1c_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // (R03)
    w1c_write_s and (wdat[B_OWN] && !rx_ev.own_done && !soft_reset) |=> !status_q[B_OWN])
    else $error("write one did not clear");
  softrst_val_a: assert property (@(posedge pclk) disable iff (!presetn) // (R05)
    soft_reset |=> status_q == STATUS_RESET) else $error("soft reset value wrong");
  hub_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // (R14)
    hub_to && !soft_reset |=> hub_reset ##1 status_q[B_HUBWD]) else $error("hub watchdog flag missing");
  coder_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // (R15)
    !hub_on |-> !coder_reset) else $error("coders reset while hub off");
  send_clr_a: assert property (@(posedge pclk) disable iff (!presetn) // (R19)
    send_cmd && !tx_ev.tx_fail && !tx_ev.enq_noreply |=> !status_q[B_TRANSMIT_ERROR_FLAG] && !status_q[B_ENQ] && !status_q[B_AVAIL])
    else $error("send command did not clear errors");
  ro_write_a: assert property (@(posedge pclk) disable iff (!presetn) // (R24)
    w1c_write_s and (!watch_hit && !watch_cmd && !soft_reset) |=> status_q[B_WATCH] == $past(status_q[B_WATCH]))
    else $error("read-only bit changed by write");

  ////////////////////////////////////////////////////////////////////////////
  // Event and command checks. An event taken at one edge shows in the status word
  // from the next; a software reset in that cycle overrides it and is left out.
  sequence send_arm_s;
    send_cmd && !soft_reset;
  endsequence
  sequence send_end_s;
    armed_q && token_rx && tx_ev.done && !send_cmd && !soft_reset;
  endsequence
  sequence hub_expire_s;
    hub_to && !soft_reset;
  endsequence

  decode_set_a: assert property ( // (R04)
    rx_ev.decode_fix && !soft_reset |=> status_q[B_DECODE] && error_info_register_q[11:8] == $past(rx_ev.decode_info))
    else $error("decoder correction not captured");
  unlock_drop_a: assert property ( // (R06)
    master_id_loaded && self_is_master && !soft_reset |=> !status_q[B_UNLOCK])
    else $error("unlock flag stuck while master");
  unlock_hold_a: assert property ( // (R06)
    master_id_loaded && !self_is_master |=> status_q[B_UNLOCK])
    else $error("unlock flag dropped early");
  watch_set_a: assert property ( // (R07)
    watch_hit && !soft_reset |=> status_q[B_WATCH])
    else $error("watch timeout not flagged");
  watch_clr_a: assert property ( // (R23)
    watch_cmd && !watch_hit && !soft_reset |=> !status_q[B_WATCH] && watch_q == 32'h0000_0000)
    else $error("watch command did not clear");
  free_set_a: assert property ( // (R08)
    rx_ev.free_done && !soft_reset |=> status_q[B_FREE])
    else $error("free-format receive not flagged");
  remote_set_a: assert property ( // (R09)
    rx_ev.remote_done && !soft_reset |=> status_q[B_REMOTE])
    else $error("remote-buffer receive not flagged");
  own_set_a: assert property ( // (R10)
    rx_ev.own_done && !soft_reset |=> status_q[B_OWN])
    else $error("own-node receive not flagged");
  sid_set_a: assert property ( // (R11)
    rx_ev.pkt_done && rx_ev.pkt_source == search_q && !soft_reset |=> status_q[B_SID])
    else $error("source id match not flagged");
  retry_set_a: assert property ( // (R12)
    tx_ev.token_retry && !soft_reset |=> status_q[B_RETRY])
    else $error("token retry not flagged");
  reply_set_a: assert property ( // (R13)
    tx_ev.reply_recover && !soft_reset |=> status_q[B_REPLY])
    else $error("reply recovery not flagged");
  hub_pulse_a: assert property ( // (R14)
    hub_expire_s |=> hub_reset ##1 !hub_reset)
    else $error("hub reset is not a single pulse");
  page_low_a: assert property ( // (R16)
    tx_ev.sent && tx_ev.sent_page_ptr <= PAGE_PTR_MAX_BAD && !soft_reset |=> status_q[B_PAGE])
    else $error("low page pointer not flagged");
  page_high_a: assert property ( // (R16)
    tx_ev.sent && tx_ev.sent_page_ptr > tx_ev.page_limit && !soft_reset |=> status_q[B_PAGE])
    else $error("page pointer past limit not flagged");
  core_set_a: assert property ( // (R17)
    |(core_src & control_q[4:1]) && !soft_reset |=> status_q[B_CORE])
    else $error("enabled core source not shown");
  enq_set_a: assert property ( // (R18)
    tx_ev.enq_noreply && !soft_reset |=> status_q[B_ENQ] && status_q[B_TRANSMIT_ERROR_FLAG])
    else $error("enquiry without reply not flagged");
  transmit_error_flag_set_a: assert property ( // (R19)
    tx_ev.tx_fail && !soft_reset |=> status_q[B_TRANSMIT_ERROR_FLAG])
    else $error("send failure not flagged");
  send_arm_a: assert property ( // (R22)
    send_arm_s |=> send_armed && !status_q[B_AVAIL])
    else $error("send command did not arm");
  send_end_a: assert property ( // (R20)
    send_end_s |=> !send_armed && status_q[B_AVAIL])
    else $error("pending send did not finish");
  tx_code_a: assert property ( // (R21)
    status_q[B_AVAIL] && status_q[B_TRANSMIT_ERROR_FLAG] && !status_q[B_ENQ] |-> tx_state == NISM_TX_DATA_ERR)
    else $error("transmit state code wrong");
  ro_avail_a: assert property ( // (R24)
    w1c_write_s and (wdat[B_AVAIL] && !tx_ev.done && !soft_reset) |=> status_q[B_AVAIL] == $past(status_q[B_AVAIL]))
    else $error("available bit changed by write");

endmodule // nism_top

/* File: test/nism_host.sv */
// APB host model that issues single register transfers.
module nism_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end
  // Read data and the error flag are taken at the edge that samples pready high.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output logic hung);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    hung = (n >= 50);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a; // Released lines do not keep the old value.
    pwdata <= ~d;
  endtask
endmodule // nism_host

/* File: test/nism_top_tb.sv */
// Self-checking bench for the interrupt status and mask block.
module nism_top_tb import nism_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HS = 10;
  localparam int HF = 5;
  localparam int WC = 20;
  logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  nism_rx_s rx_ev = '0, r;
  nism_tx_s tx_ev = '0, t;
  logic token_rx = 1'b0, hub_tx_active = 1'b0, hub_on = 1'b1, fast_rate = 1'b0;
  logic master_id_loaded = 1'b1, self_is_master = 1'b0;
  logic [3:0] core_src = 4'h0;
  logic irq, hub_reset, coder_reset, send_armed, watch_restart, remote_flags_clear;
  nism_txstate_e tx_state;
  int miscompares = 0, cmp_count = 0, watch_clears = 0;
  always #50 pclk = ~pclk;
  // Counts command strobes that restart the watch timer and clear remote flags together.
  always @(posedge pclk) begin
    if (watch_restart === 1'b1 && remote_flags_clear === 1'b1) watch_clears <= watch_clears + 1;
  end
  nism_top #(.HUB_WD_SLOW(HS), .HUB_WD_FAST(HF), .WATCH_CYCLES(WC)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_ev(rx_ev), .tx_ev(tx_ev), .token_rx(token_rx),
    .hub_tx_active(hub_tx_active), .hub_on(hub_on), .fast_rate(fast_rate),
    .master_id_loaded(master_id_loaded), .self_is_master(self_is_master), .core_src(core_src),
    .irq(irq), .hub_reset(hub_reset), .coder_reset(coder_reset), .send_armed(send_armed),
    .watch_restart(watch_restart), .remote_flags_clear(remote_flags_clear), .tx_state(tx_state));
  nism_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic hung;
    u_host.xfer(w, a, d, v, last_err, hung);
    #1; // Outputs are looked at once the access edge has settled.
    if (hung) begin
      miscompares++;
      wrap_up();
    end
  endtask
  // Status with the watch bit hidden, since its timer runs in the background.
  task automatic st();
    bus(1'b0, {2'b00, STATUS_ADDR}, '0);
    v = v & 32'hffff_efff;
  endtask
  // All event inputs pulse for one cycle together.
  task automatic ev(input nism_rx_s er, input nism_tx_s et, input logic tok);
    @(posedge pclk);
    rx_ev <= er;
    tx_ev <= et;
    token_rx <= tok;
    @(posedge pclk);
    rx_ev <= '0;
    tx_ev <= '0;
    token_rx <= 1'b0;
    @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_events();
    r = '0;
    r.err_abort = 1'b1;
    r.err_code = 3'h5;
    r.err_sender = 5'h13;
    r.decode_fix = 1'b1;
    r.decode_info = 4'ha;
    {r.free_done, r.remote_done, r.own_done, r.pkt_done} = 4'hf;
    r.pkt_source = 5'h07;
    t = '0;
    {t.token_retry, t.reply_recover, t.sent} = 3'h7;
    t.sent_page_ptr = 8'h02;
    t.page_limit = 8'h40;
    ev(r, t, 1'b0);
    st();
    chk(v, 32'h0000_eed1);
    bus(1'b0, {2'b00, ERROR_INFO_REGISTER_ADDR}, '0);
    chk(v, 32'h0000_0ab3);
    bus(1'b1, {2'b00, STATUS_ADDR}, '0);
    st();
    chk(v, 32'h0000_eed1);
    bus(1'b1, {2'b00, STATUS_ADDR}, 32'h0000_ffff);
    st();
    chk(v, 32'h0000_2001);
    r = '0;
    r.own_done = 1'b1;
    ev(r, '0, 1'b0);
    chk(irq, 1'b0);
    bus(1'b1, {2'b00, MASK_ADDR}, 32'h0000_0200);
    chk(irq, 1'b1);
    bus(1'b1, {2'b00, STATUS_ADDR}, 32'h0000_0200);
    chk(irq, 1'b0);
    bus(1'b1, {2'b00, MASK_ADDR}, '0);
  endtask
  task automatic t_match();
    bus(1'b1, {2'b00, SEARCH_ADDR}, 32'h0000_0005);
    for (int i = 5; i < 7; i++) begin
      r = '0;
      r.pkt_done = 1'b1;
      r.pkt_source = 5'(i);
      t = '0;
      t.sent = 1'b1;
      t.sent_page_ptr = (i == 5) ? 8'h41 : 8'h03;
      t.page_limit = 8'h40;
      ev(r, t, 1'b0);
      st();
      chk(v & 32'h0110, (i == 5) ? 32'h0110 : 32'h0);
      bus(1'b1, {2'b00, STATUS_ADDR}, 32'h0000_0110);
    end
  endtask
  task automatic t_send();
    t = '0;
    {t.tx_fail, t.enq_noreply} = 2'b11;
    ev('0, t, 1'b0);
    st();
    chk(v & 32'h7, 32'h7);
    chk(tx_state, NISM_TX_NO_REPLY);
    bus(1'b1, {2'b00, OPCODE_ADDR}, {24'h0, CMD_SEND});
    st();
    chk(v & 32'h7, 32'h0);
    chk({send_armed, tx_state}, {1'b1, NISM_TX_BUSY});
    t = '0;
    t.done = 1'b1;
    ev('0, t, 1'b1);
    chk(tx_state, NISM_TX_DONE);
    t = '0;
    t.tx_fail = 1'b1;
    ev('0, t, 1'b0);
    chk(tx_state, NISM_TX_DATA_ERR);
    bus(1'b1, {2'b00, STATUS_ADDR}, 32'h0000_0002);
  endtask
  task automatic t_hub(input logic on, input logic fast, input int n_exp);
    int n;
    n = 0;
    @(posedge pclk);
    hub_on <= on;
    fast_rate <= fast;
    hub_tx_active <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      #1;
    end while (hub_reset !== 1'b1 && n < 40);
    chk(n, n_exp);
    chk(coder_reset, on);
    @(posedge pclk);
    hub_tx_active <= 1'b0;
    st();
    chk(v & 32'h20, 32'h20);
    bus(1'b1, {2'b00, STATUS_ADDR}, 32'h0000_0020);
  endtask
  task automatic t_watch();
    // An expiry at the first command's edge would win; the second starts from a known phase.
    bus(1'b1, {2'b00, OPCODE_ADDR}, {24'h0, CMD_WATCH_CLR});
    bus(1'b1, {2'b00, OPCODE_ADDR}, {24'h0, CMD_WATCH_CLR});
    chk(watch_clears, 2);
    bus(1'b0, {2'b00, STATUS_ADDR}, '0);
    chk(v & 32'h1000, 32'h0);
    repeat (WC + 10) @(posedge pclk);
    bus(1'b1, {2'b00, STATUS_ADDR}, 32'h0000_1000);
    bus(1'b0, {2'b00, STATUS_ADDR}, '0);
    chk(v & 32'h1000, 32'h1000);
  endtask
  task automatic t_misc();
    @(posedge pclk);
    self_is_master <= 1'b1;
    core_src <= 4'h4;
    bus(1'b1, {2'b00, CONTROL_ADDR}, 32'h0000_0008);
    st();
    chk(v & 32'h2008, 32'h0008);
    self_is_master <= 1'b0;
    r = '0;
    r.own_done = 1'b1;
    ev(r, '0, 1'b0);
    bus(1'b1, {2'b00, CONTROL_ADDR}, 32'h0000_0001);
    bus(1'b0, {2'b00, STATUS_ADDR}, '0);
    chk(v, 32'h0000_2001);
    bus(1'b1, {2'b00, CONTROL_ADDR}, '0);
    bus(1'b0, 12'h3fc, '0);
    chk(last_err, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; reset is held for twelve cycles.
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b0, {2'b00, STATUS_ADDR}, '0);
    chk(v, {16'h0, STATUS_RESET});
    bus(1'b0, {2'b00, MASK_ADDR}, '0);
    chk({v[30:0], irq}, {15'h0, MASK_RESET, 1'b0});
    t_events();
    t_match();
    t_send();
    t_hub(1'b1, 1'b0, HS);
    t_hub(1'b0, 1'b1, HF);
    t_watch();
    t_misc();
    wrap_up();
  end
endmodule // nism_top_tb
